/* File: inc/tmr_pkg.sv */
// Purpose: Constants shared by the 16-bit capture/compare timer
// Assumes: Byte-wide register port, one clock at 125 MHz
// Notes:   Register offsets are byte indices on the register port
package tmr_pkg;
  // Register offsets
  localparam logic [4:0] ADR_CTRL_ONE   = 5'h00;
  localparam logic [4:0] ADR_CTRL_TWO   = 5'h01;
  localparam logic [4:0] ADR_STATUS     = 5'h02;
  localparam logic [4:0] ADR_CAP1_HI    = 5'h03;
  localparam logic [4:0] ADR_CAP1_LO    = 5'h04;
  localparam logic [4:0] ADR_CMP1_HI    = 5'h05;
  localparam logic [4:0] ADR_CMP1_LO    = 5'h06;
  localparam logic [4:0] ADR_CNT_HI     = 5'h07;
  localparam logic [4:0] ADR_CNT_LO     = 5'h08;
  localparam logic [4:0] ADR_ALT_HI     = 5'h09;
  localparam logic [4:0] ADR_ALT_LO     = 5'h0a;
  localparam logic [4:0] ADR_CAP2_HI    = 5'h0b;
  localparam logic [4:0] ADR_CAP2_LO    = 5'h0c;
  localparam logic [4:0] ADR_CMP2_HI    = 5'h0d;
  localparam logic [4:0] ADR_CMP2_LO    = 5'h0e;
  localparam logic [4:0] ADR_POWER      = 5'h0f;
  // Control one fields
  localparam int CTL1_CAP_IE  = 7;
  localparam int CTL1_CMP_IE  = 6;
  localparam int CTL1_OVF_IE  = 5;
  localparam int CTL1_LVL2    = 2;
  localparam int CTL1_EDGE1   = 1;
  localparam int CTL1_LVL1    = 0;
  // Control two fields
  localparam int CTL2_PIN1_EN = 7;
  localparam int CTL2_PIN2_EN = 6;
  localparam int CTL2_OPM     = 5;
  localparam int CTL2_PWM     = 4;
  localparam int CTL2_CS_HI   = 3;
  localparam int CTL2_CS_LO   = 2;
  localparam int CTL2_EDGE2   = 1;
  localparam int CTL2_EXT_EDG = 0;
  // Status fields
  localparam int ST_CAP1 = 7;
  localparam int ST_CMP1 = 6;
  localparam int ST_OVF  = 5;
  localparam int ST_CAP2 = 4;
  localparam int ST_CMP2 = 3;
  // Power control fields
  localparam int PWR_HALT = 0;
  // Reset values
  localparam logic [15:0] CNT_RESET = 16'hfffc;
  localparam logic [15:0] CMP_RESET = 16'h8000;
  localparam logic [7:0]  CTL_RESET = 8'h00;
  // Clock select codes
  localparam logic [1:0] CS_DIV4 = 2'h0;
  localparam logic [1:0] CS_DIV2 = 2'h1;
  localparam logic [1:0] CS_DIV8 = 2'h2;
  localparam logic [1:0] CS_EXT  = 2'h3;
  // Timing
  localparam int CLK_PERIOD_NS   = 8;
  localparam int EXT_MIN_FALLS   = 4;
endpackage

/* File: inc/tmr_chan_if.sv */
// Purpose: Bundle between top and one capture channel
// Assumes: Same clock as the timer core
// Notes:   Strobes are one clock long
`timescale 1ns/100ps
interface tmr_chan_if;
  logic        edge_sel;
  logic        enable;
  logic        hi_read;
  logic        lo_access;
  logic        status_seen;
  logic        pin_sync;
  logic [15:0] count;
  logic [15:0] value;
  logic        flag;
  modport core (output edge_sel, enable, hi_read, lo_access, status_seen,
                pin_sync, count, input value, flag);
  modport chan (input edge_sel, enable, hi_read, lo_access, status_seen,
                pin_sync, count, output value, flag);
endinterface

/* File: verilog/tmr_capture.sv */
// Purpose: One input-capture channel with flag and read lock
// Assumes: Pin already passed a two-stage synchroniser
// Notes:   Set of the flag wins over its clear
`timescale 1ns/100ps
module tmr_capture (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Channel bundle
  tmr_chan_if.chan ch
);
  typedef struct packed {
    logic        pin_prev;
    logic        locked;
    logic        armed;
    logic [15:0] value;
    logic        flag;
  } tmr_cap_state_type;

  tmr_cap_state_type s_q;
  tmr_cap_state_type s_d;
  logic              hit;

  always_comb begin
    s_d          = s_q;
    s_d.pin_prev = ch.pin_sync;
    // Only the pin edge picked by edge_sel counts, output-driven or not
    hit = ch.enable && !s_q.locked &&
          (ch.edge_sel ? (ch.pin_sync && !s_q.pin_prev)
                       : (!ch.pin_sync && s_q.pin_prev));
    if (ch.hi_read) begin
      s_d.locked = 1'b1;
    end
    if (ch.lo_access) begin
      s_d.locked = 1'b0;
    end
    if (ch.status_seen && s_q.flag) begin
      s_d.armed = 1'b1;
    end
    if (ch.lo_access && s_q.armed) begin
      s_d.flag  = 1'b0;
      s_d.armed = 1'b0;
    end
    if (hit) begin
      s_d.value = ch.count;
      s_d.flag  = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ch.value = s_q.value;
  assign ch.flag  = s_q.flag;

  lock_blocks_a: assert property (@(posedge clk) disable iff (!rst_b)
    s_q.locked |=> $stable(s_q.value))
    else $error("capture value changed while locked");
  flag_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    (s_q.flag && s_q.armed && ch.lo_access && !hit) |=> !s_q.flag)
    else $error("capture flag not cleared");
  capture_seen_c: cover property (@(posedge clk) disable iff (!rst_b) hit);
endmodule

/* File: verilog/tmr_compare.sv */
// Purpose: One output-compare channel with write inhibit
// Assumes: Compare evaluated on each timer tick
// Notes:   Hardware never changes the stored value
`timescale 1ns/100ps
module tmr_compare (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Register access
  input  wire logic        wr_hi,
  input  wire logic        wr_lo,
  input  wire logic [7:0]  wdata,
  // Counter side
  input  wire logic        tick,
  input  wire logic [15:0] count,
  // Results
  output logic [15:0]      value,
  output logic             match
);
  typedef struct packed {
    logic [15:0] value;
    logic        inhibit;
  } tmr_cmp_state_type;

  tmr_cmp_state_type s_q;
  tmr_cmp_state_type s_d;

  always_comb begin
    s_d = s_q;
    if (wr_hi) begin
      s_d.value[15:8] = wdata;
      s_d.inhibit     = 1'b1;
    end
    if (wr_lo) begin
      s_d.value[7:0] = wdata;
      s_d.inhibit    = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= {tmr_pkg::CMP_RESET, 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign value = s_q.value;
  assign match = tick && !s_q.inhibit && (count == s_q.value);

  inhibit_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    s_q.inhibit |-> !match)
    else $error("compare matched while inhibited");
endmodule

/* File: verilog/tmr_timer.sv */
// Purpose: 16-bit free-running timer with two captures and two compares
// Assumes: Byte register port, read data one clock after read strobe
// Notes:   External clock edges must be at least four clocks apart
//
// Overview of operation
// - Free-running 16-bit up-counter, high/low bytes
// - Alternate view; its low read keeps overflow
// - Low-byte write reloads counter with fffc
// - Clock is cpu/2, /4, /8 or external
// - Both select bits set picks external clock
// - Edge bit picks rising or falling external
// - External counts aligned to internal clock
// - High read freezes low byte until read
// - Lone low read returns live byte
// - Wrap ffff to 0000 sets overflow flag
// - Overflow request gated by enable and mask
// - Overflow clears: status read, main low access
// - Wait ignored; halt stops counting
// - Capture registers latch count on edge
// - Per-channel capture edge select bits
// - Capture sets flag, gated interrupt request
// - Capture flag clears: status read, low access
// - High read blocks capture until low access
// - One-pulse and PWM leave capture two only
// - Only the edge picked by the edge bit reaches capture
// - Compare each tick; flag, pin, interrupt
// - Compare registers software-only, reset 8000
// - Match drives programmed level; pin low at reset
// - Compare high write inhibits until low write
`timescale 1ns/100ps
module tmr_timer (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Register port
  input  wire logic [4:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // CPU state
  input  wire logic       cpu_irq_mask,
  // Pins
  input  wire logic       ext_clock_pin,
  input  wire logic       capture_pin1,
  input  wire logic       capture_pin2,
  output logic            compare_pin1,
  output logic            compare_pin1_oe,
  output logic            compare_pin2,
  output logic            compare_pin2_oe,
  // Interrupt request
  output logic            irq
);
  typedef struct packed {
    logic [1:0]  ext_sync;
    logic [1:0]  cap1_sync;
    logic [1:0]  cap2_sync;
    logic        ext_prev;
    logic        ext_pend;
    logic [2:0]  pre;
    logic [15:0] count;
    logic [7:0]  low_buf;
    logic        low_held;
    logic        ovf_flag;
    logic        ovf_armed;
    logic        cmp1_flag;
    logic        cmp2_flag;
    logic        cmp1_armed;
    logic        cmp2_armed;
    logic [7:0]  ctl_one;
    logic [7:0]  ctl_two;
    logic        halt;
    logic        pin1;
    logic        pin2;
    logic [7:0]  rdata;
    logic        irq;
  } tmr_state_type;

  tmr_state_type s_q;
  tmr_state_type s_d;
  logic          tick;
  logic          ext_edge;
  logic          wrap;
  logic          pulse_mode;
  logic [15:0]   cmp1_val;
  logic [15:0]   cmp2_val;
  logic          match1;
  logic          match2;
  logic [7:0]    status;
  logic          rd_status;
  logic          acc_cnt_lo;

  tmr_chan_if cap1 ();
  tmr_chan_if cap2 ();

  assign pulse_mode = s_q.ctl_two[tmr_pkg::CTL2_OPM] ||
                      s_q.ctl_two[tmr_pkg::CTL2_PWM];
  assign rd_status  = rd && (addr == tmr_pkg::ADR_STATUS);
  assign acc_cnt_lo = (rd || wr) && (addr == tmr_pkg::ADR_CNT_LO);
  assign status = {cap1.flag, s_q.cmp1_flag, s_q.ovf_flag, cap2.flag,
                   s_q.cmp2_flag, 3'h0};

  // Capture channel one is lost in pulse modes
  assign cap1.edge_sel    = s_q.ctl_one[tmr_pkg::CTL1_EDGE1];
  assign cap1.enable      = !pulse_mode;
  assign cap1.hi_read     = rd && (addr == tmr_pkg::ADR_CAP1_HI);
  assign cap1.lo_access   = (rd || wr) && (addr == tmr_pkg::ADR_CAP1_LO);
  assign cap1.status_seen = rd_status;
  assign cap1.pin_sync    = s_q.cap1_sync[1];
  assign cap1.count       = s_q.count;
  assign cap2.edge_sel    = s_q.ctl_two[tmr_pkg::CTL2_EDGE2];
  assign cap2.enable      = 1'b1;
  assign cap2.hi_read     = rd && (addr == tmr_pkg::ADR_CAP2_HI);
  assign cap2.lo_access   = (rd || wr) && (addr == tmr_pkg::ADR_CAP2_LO);
  assign cap2.status_seen = rd_status;
  assign cap2.pin_sync    = s_q.cap2_sync[1];
  assign cap2.count       = s_q.count;

  tmr_capture u_cap1 (
    .clk   (clk),
    .rst_b (rst_b),
    .ch    (cap1)
  );

  tmr_capture u_cap2 (
    .clk   (clk),
    .rst_b (rst_b),
    .ch    (cap2)
  );

  tmr_compare u_cmp1 (
    .clk   (clk),
    .rst_b (rst_b),
    .wr_hi (wr && (addr == tmr_pkg::ADR_CMP1_HI)),
    .wr_lo (wr && (addr == tmr_pkg::ADR_CMP1_LO)),
    .wdata (wdata),
    .tick  (tick),
    .count (s_q.count),
    .value (cmp1_val),
    .match (match1)
  );

  tmr_compare u_cmp2 (
    .clk   (clk),
    .rst_b (rst_b),
    .wr_hi (wr && (addr == tmr_pkg::ADR_CMP2_HI)),
    .wr_lo (wr && (addr == tmr_pkg::ADR_CMP2_LO)),
    .wdata (wdata),
    .tick  (tick),
    .count (s_q.count),
    .value (cmp2_val),
    .match (match2)
  );

  // External edge taken from synchronised copy only
  assign ext_edge = s_q.ctl_two[tmr_pkg::CTL2_EXT_EDG]
                  ? (s_q.ext_sync[1] && !s_q.ext_prev)
                  : (!s_q.ext_sync[1] && s_q.ext_prev);

  always_comb begin
    unique case (s_q.ctl_two[tmr_pkg::CTL2_CS_HI:tmr_pkg::CTL2_CS_LO])
      tmr_pkg::CS_DIV2: tick = (s_q.pre[0] == 1'b1);
      tmr_pkg::CS_DIV4: tick = (s_q.pre[1:0] == 2'h3);
      tmr_pkg::CS_DIV8: tick = (s_q.pre == 3'h7);
      tmr_pkg::CS_EXT:  tick = s_q.ext_pend;
    endcase
    // Halt freezes the prescaler and count; wait has no input here at all
    tick = tick && !s_q.halt;
  end

  assign wrap = tick && (s_q.count == 16'hffff);

  always_comb begin
    s_d           = s_q;
    s_d.ext_sync  = {s_q.ext_sync[0], ext_clock_pin};
    s_d.cap1_sync = {s_q.cap1_sync[0], capture_pin1};
    s_d.cap2_sync = {s_q.cap2_sync[0], capture_pin2};
    s_d.ext_prev  = s_q.ext_sync[1];
    // One clock of delay aligns the external count to the next edge
    s_d.ext_pend  = ext_edge;
    s_d.pre       = s_q.halt ? s_q.pre : s_q.pre + 3'h1;
    if (tick) begin
      s_d.count = s_q.count + 16'h0001;
    end
    if (wr && (addr == tmr_pkg::ADR_CNT_LO || addr == tmr_pkg::ADR_ALT_LO)) begin
      s_d.count = tmr_pkg::CNT_RESET;
    end
    s_d.rdata = 8'h00;
    if (rd) begin
      unique case (addr)
        tmr_pkg::ADR_CTRL_ONE: s_d.rdata = s_q.ctl_one;
        tmr_pkg::ADR_CTRL_TWO: s_d.rdata = s_q.ctl_two;
        tmr_pkg::ADR_STATUS:   s_d.rdata = status;
        tmr_pkg::ADR_CAP1_HI:  s_d.rdata = cap1.value[15:8];
        tmr_pkg::ADR_CAP1_LO:  s_d.rdata = cap1.value[7:0];
        tmr_pkg::ADR_CMP1_HI:  s_d.rdata = cmp1_val[15:8];
        tmr_pkg::ADR_CMP1_LO:  s_d.rdata = cmp1_val[7:0];
        tmr_pkg::ADR_CAP2_HI:  s_d.rdata = cap2.value[15:8];
        tmr_pkg::ADR_CAP2_LO:  s_d.rdata = cap2.value[7:0];
        tmr_pkg::ADR_CMP2_HI:  s_d.rdata = cmp2_val[15:8];
        tmr_pkg::ADR_CMP2_LO:  s_d.rdata = cmp2_val[7:0];
        tmr_pkg::ADR_POWER:    s_d.rdata = {7'h00, s_q.halt};
        tmr_pkg::ADR_CNT_HI, tmr_pkg::ADR_ALT_HI: begin
          s_d.rdata = s_q.count[15:8];
          if (!s_q.low_held) begin
            s_d.low_buf  = s_q.count[7:0];
            s_d.low_held = 1'b1;
          end
        end
        tmr_pkg::ADR_CNT_LO, tmr_pkg::ADR_ALT_LO: begin
          s_d.rdata    = s_q.low_held ? s_q.low_buf : s_q.count[7:0];
          s_d.low_held = 1'b0;
        end
        default: s_d.rdata = 8'h00;
      endcase
    end
    if (wr) begin
      unique case (addr)
        tmr_pkg::ADR_CTRL_ONE: s_d.ctl_one = wdata;
        tmr_pkg::ADR_CTRL_TWO: s_d.ctl_two = wdata;
        tmr_pkg::ADR_POWER:    s_d.halt = wdata[tmr_pkg::PWR_HALT];
        default: s_d.halt = s_q.halt;
      endcase
    end
    // Two-step clears; a same-cycle set overrides them
    if (rd_status) begin
      s_d.ovf_armed  = s_q.ovf_armed | s_q.ovf_flag;
      s_d.cmp1_armed = s_q.cmp1_armed | s_q.cmp1_flag;
      s_d.cmp2_armed = s_q.cmp2_armed | s_q.cmp2_flag;
    end
    // Alternate low byte deliberately absent here
    if (acc_cnt_lo && s_q.ovf_armed) begin
      s_d.ovf_flag  = 1'b0;
      s_d.ovf_armed = 1'b0;
    end
    if ((rd || wr) && addr == tmr_pkg::ADR_CMP1_LO && s_q.cmp1_armed) begin
      s_d.cmp1_flag  = 1'b0;
      s_d.cmp1_armed = 1'b0;
    end
    if ((rd || wr) && addr == tmr_pkg::ADR_CMP2_LO && s_q.cmp2_armed) begin
      s_d.cmp2_flag  = 1'b0;
      s_d.cmp2_armed = 1'b0;
    end
    if (wrap) begin
      s_d.ovf_flag = 1'b1;
    end
    if (match1) begin
      s_d.cmp1_flag = 1'b1;
      s_d.pin1      = s_q.ctl_one[tmr_pkg::CTL1_LVL1];
    end
    if (match2) begin
      s_d.cmp2_flag = 1'b1;
      s_d.pin2      = s_q.ctl_one[tmr_pkg::CTL1_LVL2];
    end
    // Flags pend until enable set and mask clear
    s_d.irq = !cpu_irq_mask && (
      (s_q.ctl_one[tmr_pkg::CTL1_OVF_IE] && s_d.ovf_flag) ||
      (s_q.ctl_one[tmr_pkg::CTL1_CMP_IE] &&
        (s_d.cmp1_flag || s_d.cmp2_flag)) ||
      (s_q.ctl_one[tmr_pkg::CTL1_CAP_IE] &&
        (cap1.flag || cap2.flag)));
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q         <= '0;
      s_q.count   <= tmr_pkg::CNT_RESET;
      s_q.ctl_one <= tmr_pkg::CTL_RESET;
      s_q.ctl_two <= tmr_pkg::CTL_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata           = s_q.rdata;
  assign irq             = s_q.irq;
  assign compare_pin1    = s_q.pin1;
  assign compare_pin2    = s_q.pin2;
  assign compare_pin1_oe = s_q.ctl_two[tmr_pkg::CTL2_PIN1_EN];
  assign compare_pin2_oe = s_q.ctl_two[tmr_pkg::CTL2_PIN2_EN];

  count_step_a: assert property (@(posedge clk) disable iff (!rst_b)
    (tick && !wr) |=> s_q.count == $past(s_q.count) + 16'h0001)
    else $error("counter did not advance on tick");
  reload_val_a: assert property (@(posedge clk) disable iff (!rst_b)
    (wr && (addr == tmr_pkg::ADR_CNT_LO || addr == tmr_pkg::ADR_ALT_LO))
    |=> s_q.count == tmr_pkg::CNT_RESET)
    else $error("low write did not reload counter");
  div2_rate_a: assert property (@(posedge clk) disable iff (!rst_b)
    (s_q.ctl_two[3:2] == tmr_pkg::CS_DIV2 && !s_q.halt && tick)
    |=> !tick)
    else $error("divide by two ticked twice in a row");
  halt_stop_a: assert property (@(posedge clk) disable iff (!rst_b)
    s_q.halt |-> !tick)
    else $error("counter ticked in halt");
  ovf_set_a: assert property (@(posedge clk) disable iff (!rst_b)
    wrap |=> s_q.ovf_flag && s_q.count == 16'h0000 ||
    s_q.ovf_flag)
    else $error("overflow flag not set on wrap");
  alt_keeps_a: assert property (@(posedge clk) disable iff (!rst_b)
    (s_q.ovf_flag && rd && addr == tmr_pkg::ADR_ALT_LO) |=> s_q.ovf_flag)
    else $error("alternate low read cleared overflow");
  ovf_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    (s_q.ovf_flag && !s_q.ovf_armed && acc_cnt_lo) |=> s_q.ovf_flag)
    else $error("overflow cleared without status read");
  low_frozen_a: assert property (@(posedge clk) disable iff (!rst_b)
    (rd && addr == tmr_pkg::ADR_CNT_HI && s_q.low_held)
    |=> $stable(s_q.low_buf))
    else $error("buffered low byte moved on second high read");
  irq_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
    $past(cpu_irq_mask) |-> !irq)
    else $error("interrupt raised while masked");
  cap1_off_a: assert property (@(posedge clk) disable iff (!rst_b)
    (pulse_mode && !cap1.flag) |=> !cap1.flag)
    else $error("capture one fired in pulse mode");
  pin_drive_a: assert property (@(posedge clk) disable iff (!rst_b)
    match1 |=> compare_pin1 == $past(s_q.ctl_one[tmr_pkg::CTL1_LVL1]))
    else $error("compare pin not driven to level");

  wrap_seen_c: cover property (@(posedge clk) disable iff (!rst_b) wrap);
  match_seen_c: cover property (@(posedge clk) disable iff (!rst_b) match2);
  ext_tick_c: cover property (@(posedge clk) disable iff (!rst_b)
    s_q.ctl_two[3:2] == tmr_pkg::CS_EXT && tick);
endmodule

/* File: tb/tmr_pin_model.sv */
// Purpose: Far-side model of the timer pins
// Assumes: Same clock as the bench
// Notes:   Pins are always driven, never released
`timescale 1ns/100ps
module tmr_pin_model (
  // Clock
  input  wire logic clk,
  // Pins toward the timer
  output logic      ext_clock_pin,
  output logic      capture_pin1,
  output logic      capture_pin2
);
  initial begin
    ext_clock_pin = 1'b0;
    capture_pin1  = 1'b0;
    capture_pin2  = 1'b0;
  end
  // Six clocks a level, margin over the sync delay
  task automatic ext_toggle(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (6) @(posedge clk);
      ext_clock_pin <= ~ext_clock_pin;
    end
  endtask
  task automatic cap_toggle(input int ch);
    @(posedge clk);
    if (ch == 1) begin
      capture_pin1 <= ~capture_pin1;
    end else begin
      capture_pin2 <= ~capture_pin2;
    end
    repeat (8) @(posedge clk);
  endtask
endmodule

/* File: tb/timer16_capture_compare_tb.sv */
// Purpose: Self-checking bench for the capture/compare timer
// Assumes: Register port answers one clock after the strobe
// Notes:   Prescaler phase is unknown, so timed counts allow slack
`timescale 1ns/100ps
module timer16_capture_compare_tb;
  logic        clk;
  logic        rst_b;
  logic [4:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic        cpu_irq_mask;
  logic        ext_clock_pin;
  logic        capture_pin1;
  logic        capture_pin2;
  logic        compare_pin1;
  logic        compare_pin1_oe;
  logic        compare_pin2;
  logic        compare_pin2_oe;
  logic        irq;
  logic [15:0] lfsr_q;
  int          n_errors;
  int          checks_done;

  tmr_timer dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .cpu_irq_mask(cpu_irq_mask),
    .ext_clock_pin(ext_clock_pin), .capture_pin1(capture_pin1),
    .capture_pin2(capture_pin2), .compare_pin1(compare_pin1),
    .compare_pin1_oe(compare_pin1_oe), .compare_pin2(compare_pin2),
    .compare_pin2_oe(compare_pin2_oe), .irq(irq));
  tmr_pin_model pins (.clk(clk), .ext_clock_pin(ext_clock_pin),
    .capture_pin1(capture_pin1), .capture_pin2(capture_pin2));

  always #4 clk = ~clk;

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Slack window for counts whose prescaler phase is unknown
  function automatic logic near(input logic [15:0] s, e, input int t);
    logic [15:0] d;
    d = s - e;
    // Negate in 16 bits; the compare would widen it otherwise
    return (d <= t) || (16'(16'h0000 - d) <= t);
  endfunction
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic rd_reg(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic rd16(input logic [4:0] a, output logic [15:0] v);
    rd_reg(a, v[15:8]);
    rd_reg(a + 5'h01, v[7:0]);
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #(8 * 20000);
    n_errors++;
    end_sim();
  end

  initial begin
    logic [7:0]  b;
    logic [15:0] v;
    logic [15:0] w;
    int          k;
    int          r;
    clk = 1'b0;
    rst_b = 1'b0;
    addr = 5'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    cpu_irq_mask = 1'b1;
    lfsr_q = 16'h0021;
    n_errors = 0;
    checks_done = 0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    check("pin1 rst", {15'h0, compare_pin1}, 16'h0000);
    rd16(tmr_pkg::ADR_CMP1_HI, v);
    check("cmp1 rst", v, tmr_pkg::CMP_RESET);
    rd16(tmr_pkg::ADR_CMP2_HI, v);
    check("cmp2 rst", v, tmr_pkg::CMP_RESET);
    // Halt, then reload: count must sit at the reload value
    wr_reg(tmr_pkg::ADR_POWER, 8'h01);
    rd_reg(tmr_pkg::ADR_STATUS, b);
    wr_reg(tmr_pkg::ADR_CNT_LO, 8'h5a);
    repeat (50) @(posedge clk);
    rd16(tmr_pkg::ADR_CNT_HI, v);
    check("reload", v, tmr_pkg::CNT_RESET);
    rd_reg(tmr_pkg::ADR_STATUS, b);
    check("ovf clr", {15'h0, b[5]}, 16'h0000);
    // Overflow with mask then unmask
    wr_reg(tmr_pkg::ADR_CTRL_TWO, 8'h04);
    wr_reg(tmr_pkg::ADR_CTRL_ONE, 8'h20);
    wr_reg(tmr_pkg::ADR_POWER, 8'h00);
    repeat (30) @(posedge clk);
    rd_reg(tmr_pkg::ADR_STATUS, b);
    check("ovf set", {15'h0, b[5]}, 16'h0001);
    check("irq mask", {15'h0, irq}, 16'h0000);
    cpu_irq_mask <= 1'b0;
    repeat (3) @(posedge clk);
    check("irq pend", {15'h0, irq}, 16'h0001);
    rd_reg(tmr_pkg::ADR_ALT_LO, b);
    rd_reg(tmr_pkg::ADR_STATUS, b);
    check("alt keep", {15'h0, b[5]}, 16'h0001);
    rd_reg(tmr_pkg::ADR_CNT_LO, b);
    rd_reg(tmr_pkg::ADR_STATUS, b);
    check("ovf gone", {15'h0, b[5]}, 16'h0000);
    // Low byte frozen across a second high read
    lfsr_q = lfsr_next(lfsr_q);
    k = 40 + int'(lfsr_q[5:0]);
    rd_reg(tmr_pkg::ADR_CNT_HI, v[15:8]);
    repeat (k) @(posedge clk);
    rd_reg(tmr_pkg::ADR_CNT_HI, b);
    rd_reg(tmr_pkg::ADR_CNT_LO, v[7:0]);
    rd16(tmr_pkg::ADR_ALT_HI, w);
    check("latch", {15'h0, near(w, v + 16'((k + 6) / 2), 4)}, 16'h1);
    repeat (k) @(posedge clk);
    rd_reg(tmr_pkg::ADR_CNT_LO, b);
    v = w + 16'((k + 4) / 2);
    check("live lo", {15'h0, near({v[15:8], b}, v, 4)}, 16'h1);
    // Prescaler choices
    for (int i = 0; i < 3; i++) begin
      r = 2 << i;
      b = (i == 0) ? 8'h04 : (i == 1) ? 8'h00 : 8'h08;
      wr_reg(tmr_pkg::ADR_CTRL_TWO, b);
      wr_reg(tmr_pkg::ADR_ALT_LO, 8'h00);
      repeat (200) @(posedge clk);
      rd16(tmr_pkg::ADR_ALT_HI, w);
      v = tmr_pkg::CNT_RESET + 16'(202 / r);
      check("prescale", {15'h0, near(w, v, 2)}, 16'h1);
    end
    // External clock, both active edges
    for (int e = 0; e < 2; e++) begin
      wr_reg(tmr_pkg::ADR_CTRL_TWO, 8'h0c | 8'(e));
      wr_reg(tmr_pkg::ADR_CNT_LO, 8'h00);
      r = (ext_clock_pin == 1'b0) ? 3 : 2;
      pins.ext_toggle(5);
      repeat (10) @(posedge clk);
      rd16(tmr_pkg::ADR_ALT_HI, w);
      v = tmr_pkg::CNT_RESET + 16'((e == 1) ? r : 5 - r);
      check("ext cnt", w, v);
    end
    // Capture one, count frozen with no external edges
    wr_reg(tmr_pkg::ADR_CTRL_ONE, 8'h82);
    pins.cap_toggle(1);
    rd_reg(tmr_pkg::ADR_STATUS, b);
    check("cap1 flag", {15'h0, b[7]}, 16'h0001);
    check("cap irq", {15'h0, irq}, 16'h0001);
    rd16(tmr_pkg::ADR_CAP1_HI, v);
    check("cap1 val", v, w);
    rd_reg(tmr_pkg::ADR_STATUS, b);
    check("cap1 clr", {15'h0, b[7]}, 16'h0000);
    rd_reg(tmr_pkg::ADR_CAP1_HI, b);
    pins.cap_toggle(1);
    pins.cap_toggle(1);
    rd_reg(tmr_pkg::ADR_STATUS, b);
    check("cap1 lock", {15'h0, b[7]}, 16'h0000);
    rd_reg(tmr_pkg::ADR_CAP1_LO, b);
    pins.cap_toggle(1);
    rd_reg(tmr_pkg::ADR_STATUS, b);
    check("cap1 fall", {15'h0, b[7]}, 16'h0000);
    pins.cap_toggle(1);
    rd_reg(tmr_pkg::ADR_STATUS, b);
    check("cap1 rise", {15'h0, b[7]}, 16'h0001);
    rd_reg(tmr_pkg::ADR_CAP1_LO, b);
    // One-pulse leaves only capture two; its edge is falling
    wr_reg(tmr_pkg::ADR_CTRL_TWO, 8'h2c);
    pins.cap_toggle(1);
    pins.cap_toggle(1);
    pins.cap_toggle(2);
    pins.cap_toggle(2);
    rd_reg(tmr_pkg::ADR_STATUS, b);
    check("opm cap", {14'h0, b[7], b[4]}, 16'h0001);
    // Compare one runs, compare two held by its high write
    wr_reg(tmr_pkg::ADR_CTRL_ONE, 8'h45);
    wr_reg(tmr_pkg::ADR_CTRL_TWO, 8'hc4);
    wr_reg(tmr_pkg::ADR_CMP2_HI, 8'h00);
    wr_reg(tmr_pkg::ADR_CMP1_HI, 8'h00);
    wr_reg(tmr_pkg::ADR_CMP1_LO, 8'h02);
    wr_reg(tmr_pkg::ADR_CNT_LO, 8'h00);
    repeat (30) @(posedge clk);
    rd_reg(tmr_pkg::ADR_STATUS, b);
    check("cmp flags", {14'h0, b[6], b[3]}, 16'h0002);
    check("cmp pin", {14'h0, compare_pin1, compare_pin1_oe}, 16'h3);
    check("cmp2 pin", {14'h0, compare_pin2, compare_pin2_oe}, 16'h1);
    lfsr_q = lfsr_next(lfsr_q);
    wr_reg(tmr_pkg::ADR_CMP2_LO, {4'h3, lfsr_q[3:0]});
    repeat (120) @(posedge clk);
    rd_reg(tmr_pkg::ADR_STATUS, b);
    check("cmp2 on", {15'h0, b[3]}, 16'h0001);
    check("cmp2 lvl", {14'h0, compare_pin2, compare_pin2_oe}, 16'h3);
    check("cmp irq", {15'h0, irq}, 16'h0001);
    rd16(tmr_pkg::ADR_CMP1_HI, v);
    check("cmp1 keep", v, 16'h0002);
    end_sim();
  end
endmodule
